// >>> core/dbio_pkg.sv
// Package: constants, types and decode helper for the digital I/O bank
//
// Behaviour
// RULE_01 - Each input uses soft bit when its select bit is 1, else the pin.
// RULE_02 - Soft bits one to nine sit at bits 0..8; register reads at most 01ff.
// RULE_03 - Reading input state returns effective levels after source selection; panel reads of it return 0.
// RULE_04 - Writing input state updates only stored soft bits.
// RULE_05 - Keypad state is read-only and shows which panel keys are pressed.
// RULE_06 - Output state is read-only, 0..3f, same value via panel or link.
// RULE_07 - Codes 1,2 start speed/torque offset; 3,4 start V/W current offset.
// RULE_08 - Code 5 starts all four offset calibrations together.
// RULE_09 - Code 6 starts converter calibration; 0 reserved; range 0..6, reset 0.
// RULE_10 - Calibration commands act only while the guard enables calibration.
// RULE_11 - Host calibrates only with servo off and analog inputs disconnected.
// RULE_12 - Writes to keypad and output state are ignored.
package dbio_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 16;
    localparam int IN_W = 9;
    localparam int KEY_W = 5;
    localparam int OUT_W = 6;
    localparam int CODE_W = 3;

    localparam logic [ADDR_W-1:0] INPUT_STATE_OFS = 16'h040e;
    localparam logic [ADDR_W-1:0] KEYPAD_STATE_OFS = 16'h0410;
    localparam logic [ADDR_W-1:0] OUTPUT_STATE_OFS = 16'h0412;
    localparam logic [ADDR_W-1:0] CAL_CMD_OFS = 16'h0414;

    localparam int SOFT_LSB = 0;
    localparam logic [IN_W-1:0] SOFT_RESET = 9'h000;
    localparam logic [CODE_W-1:0] CAL_RESET = 3'h0;

    localparam logic [CODE_W-1:0] CAL_RESERVED = 3'h0;
    localparam logic [CODE_W-1:0] CAL_SPEED = 3'h1;
    localparam logic [CODE_W-1:0] CAL_TORQUE = 3'h2;
    localparam logic [CODE_W-1:0] CAL_CUR_V = 3'h3;
    localparam logic [CODE_W-1:0] CAL_CUR_W = 3'h4;
    localparam logic [CODE_W-1:0] CAL_ALL = 3'h5;
    localparam logic [CODE_W-1:0] CAL_ADC = 3'h6;
    localparam logic [DATA_W-1:0] CAL_MAX = 16'h0006;

    typedef struct packed {
        logic wr;
        logic rd;
        logic panel;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } dbio_req_t;

    typedef struct packed {
        logic speed;
        logic torque;
        logic curV;
        logic curW;
        logic adc;
    } dbio_cal_t;

    function automatic logic dbio_hit(input logic [ADDR_W-1:0] addr,
                                      input logic [ADDR_W-1:0] ofs);
        dbio_hit = (addr == ofs);
    endfunction : dbio_hit
endpackage : dbio_pkg

// >>> core/dbio_cal_issue.sv
// Calibration start issuer: turns an accepted command into start pulses
`timescale 1ns/1ps
`default_nettype none
module dbio_cal_issue
    import dbio_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic reset_n, // Async reset, active low
    input wire logic cmdWrite, // Legal nonzero code written this cycle
    input wire logic [CODE_W-1:0] cmdCode, // Written code
    input wire logic guardEnable, // Calibration unlocked
    output var dbio_cal_t calStart // One-cycle start pulses
);
    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire logic accept = cmdWrite && guardEnable; // RULE_10
    dbio_cal_t startNext;
    assign startNext.speed = accept &&
        (cmdCode == CAL_SPEED || cmdCode == CAL_ALL); // RULE_07 RULE_08
    assign startNext.torque = accept &&
        (cmdCode == CAL_TORQUE || cmdCode == CAL_ALL); // RULE_07 RULE_08
    assign startNext.curV = accept &&
        (cmdCode == CAL_CUR_V || cmdCode == CAL_ALL); // RULE_07 RULE_08
    assign startNext.curW = accept &&
        (cmdCode == CAL_CUR_W || cmdCode == CAL_ALL); // RULE_07 RULE_08
    assign startNext.adc = accept && (cmdCode == CAL_ADC); // RULE_09

    // ------------------------------------------------------------
    // Pulse register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            calStart <= '0;
        end else begin
            calStart <= startNext;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    cal_all_four_a: assert property (@(posedge clk) disable iff (!reset_n)
        cmdWrite && guardEnable && cmdCode == CAL_ALL |=>
        calStart == 5'b11110) // RULE_08
        else $error("code 5 did not start all four offsets");
    cal_guard_a: assert property (@(posedge clk) disable iff (!reset_n)
        !guardEnable |=> calStart == '0) // RULE_10
        else $error("calibration started while guard locked");
    cal_code_a: assert property (@(posedge clk) disable iff (!reset_n)
        cmdWrite && guardEnable && cmdCode == CAL_CUR_W |=>
        calStart == 5'b00010) // RULE_07
        else $error("code 4 did not start only the W phase");
    cal_adc_a: assert property (@(posedge clk) disable iff (!reset_n)
        cmdWrite && guardEnable && cmdCode == CAL_ADC |=>
        calStart == 5'b00001) // RULE_09
        else $error("code 6 did not start only the converter");
    cal_all_c: cover property (@(posedge clk) disable iff (!reset_n)
        calStart == 5'b11110);
endmodule : dbio_cal_issue
`default_nettype wire

// >>> core/dbio_param_bank.sv
// Digital I/O parameter bank: input, keypad, output and calibration registers
`timescale 1ns/1ps
`default_nettype none
module dbio_param_bank
    import dbio_pkg::*;
(
    input wire logic clk, // System clock, 20 MHz
    input wire logic reset_n, // Async reset, active low
    input wire dbio_req_t req, // Parameter access request
    output logic [DATA_W-1:0] rdData, // Read data, registered
    output logic rdValid, // Read data valid pulse
    output logic wrDone, // Write accepted pulse
    input wire logic [IN_W-1:0] hwInputPins, // Hardware input levels
    input wire logic [IN_W-1:0] inputSourceSelect, // 1 = soft bit
    input wire logic [KEY_W-1:0] keyPressed, // Panel keys, 1 = pressed
    input wire logic [OUT_W-1:0] outputPins, // Digital output levels
    input wire logic specialParamGuard, // Calibration unlocked
    output logic [IN_W-1:0] effInputs, // Effective input levels
    output var dbio_cal_t calStart // Calibration start pulses
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [IN_W-1:0] softInputBits_reg;
    logic [IN_W-1:0] softInputBits_next;
    logic [IN_W-1:0] hwPins_reg;
    logic [KEY_W-1:0] keypadState_reg;
    logic [OUT_W-1:0] outputState_reg;
    logic [CODE_W-1:0] calibrationCmd_reg;
    logic [CODE_W-1:0] calibrationCmd_next;
    logic [DATA_W-1:0] rdData_next;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire logic hitInput = dbio_hit(req.addr, INPUT_STATE_OFS);
    wire logic hitKeypad = dbio_hit(req.addr, KEYPAD_STATE_OFS);
    wire logic hitOutput = dbio_hit(req.addr, OUTPUT_STATE_OFS);
    wire logic hitCal = dbio_hit(req.addr, CAL_CMD_OFS);
    // Input state cannot be reached from the panel
    wire logic inputOpen = hitInput && !req.panel;
    wire logic calLegal = req.data <= CAL_MAX; // RULE_09
    wire logic wrSoft = req.wr && inputOpen; // RULE_04
    wire logic wrCal = req.wr && hitCal && calLegal; // RULE_09
    wire logic rdAny = req.rd && !req.wr;

    // ------------------------------------------------------------
    // Source selection
    // ------------------------------------------------------------
    wire logic [IN_W-1:0] combined;
    genvar gi;
    generate
        for (gi = 0; gi < IN_W; gi++) begin : g_sel
            assign combined[gi] = inputSourceSelect[gi] ?
                softInputBits_reg[gi] : hwPins_reg[gi]; // RULE_01
        end
    endgenerate

    // ------------------------------------------------------------
    // Next values
    // ------------------------------------------------------------
    assign softInputBits_next = wrSoft ?
        req.data[SOFT_LSB +: IN_W] : softInputBits_reg; // RULE_02 RULE_04
    assign calibrationCmd_next = wrCal ?
        req.data[CODE_W-1:0] : calibrationCmd_reg; // RULE_09

    // Keypad and output state have no write path
    wire logic [DATA_W-1:0] readInput =
        {{(DATA_W-IN_W){1'b0}}, combined}; // RULE_02 RULE_03
    wire logic [DATA_W-1:0] readKeypad =
        {{(DATA_W-KEY_W){1'b0}}, keypadState_reg}; // RULE_05 RULE_12
    wire logic [DATA_W-1:0] readOutput =
        {{(DATA_W-OUT_W){1'b0}}, outputState_reg}; // RULE_06 RULE_12
    wire logic [DATA_W-1:0] readCal =
        {{(DATA_W-CODE_W){1'b0}}, calibrationCmd_reg};

    assign rdData_next = inputOpen ? readInput :
        hitKeypad ? readKeypad :
        hitOutput ? readOutput :
        hitCal ? readCal : '0;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            softInputBits_reg <= SOFT_RESET;
            calibrationCmd_reg <= CAL_RESET;
        end else begin
            softInputBits_reg <= softInputBits_next;
            calibrationCmd_reg <= calibrationCmd_next;
        end
    end

    // Sampled status of pins, keys and outputs
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hwPins_reg <= '0;
            keypadState_reg <= '0;
            outputState_reg <= '0;
        end else begin
            hwPins_reg <= hwInputPins;
            keypadState_reg <= keyPressed; // RULE_05
            outputState_reg <= outputPins; // RULE_06
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            effInputs <= '0;
        end else begin
            effInputs <= combined; // RULE_01
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdData <= '0;
            rdValid <= 1'b0;
            wrDone <= 1'b0;
        end else begin
            rdData <= rdAny ? rdData_next : rdData;
            rdValid <= rdAny;
            wrDone <= req.wr;
        end
    end

    // ------------------------------------------------------------
    // Calibration issue
    // ------------------------------------------------------------
    dbio_cal_issue u_cal (
        .clk(clk),
        .reset_n(reset_n),
        .cmdWrite(wrCal && req.data[CODE_W-1:0] != CAL_RESERVED),
        .cmdCode(req.data[CODE_W-1:0]),
        .guardEnable(specialParamGuard), // RULE_10
        .calStart(calStart)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    eff_select_a: assert property ( // RULE_01
        ##1 effInputs == (($past(inputSourceSelect) & $past(softInputBits_reg))
        | (~$past(inputSourceSelect) & $past(hwPins_reg))))
        else $error("effective inputs ignore source select");

    input_range_a: assert property ( // RULE_02
        rdValid |-> !$past(inputOpen) || rdData[DATA_W-1:IN_W] == '0)
        else $error("input state read above bit 8");

    input_read_a: assert property ( // RULE_03
        rdAny && inputOpen |=> rdData == {7'h00, $past(combined)})
        else $error("input state read not the combined levels");

    soft_write_a: assert property ( // RULE_04
        wrSoft |=> softInputBits_reg == $past(req.data[IN_W-1:0]))
        else $error("soft bits not updated by write");

    soft_hold_a: assert property ( // RULE_04
        !wrSoft |=> $stable(softInputBits_reg))
        else $error("soft bits changed without a write");

    keypad_read_a: assert property ( // RULE_05
        rdAny && hitKeypad |=> rdValid && rdData[DATA_W-1:KEY_W] == '0)
        else $error("keypad read set bits above the keys");

    key_track_a: assert property ( // RULE_05
        rdAny && hitKeypad |=> rdData == {11'h000, $past(keypadState_reg)})
        else $error("keypad read wrong");

    output_read_a: assert property ( // RULE_06
        rdAny && hitOutput |=> rdData == {10'h000, $past(outputState_reg)})
        else $error("output state read differs by path");

    cal_range_a: assert property ( // RULE_09
        calibrationCmd_reg <= 3'h6)
        else $error("calibration code out of range");

    cal_pulse_a: assert property ( // RULE_07
        wrCal && specialParamGuard && req.data[2:0] == 3'h1 |=>
        calStart.speed && !calStart.torque)
        else $error("code 1 did not start speed offset only");

    ro_write_a: assert property ( // RULE_12
        req.wr && (hitKeypad || hitOutput) |=>
        $stable(softInputBits_reg) && $stable(calibrationCmd_reg))
        else $error("read-only write disturbed a register");

    panel_input_c: cover property (req.rd && hitInput && req.panel);
    soft_mix_c: cover property (wrSoft ##1 inputSourceSelect != '0);
    cal_guard_c: cover property (wrCal && !specialParamGuard);
    out_read_c: cover property (rdAny && hitOutput && req.panel);
endmodule : dbio_param_bank
`default_nettype wire

// >>> sim/dbio_field_model.sv
// Field-side model: input pins, panel keys, output levels, drive state
`timescale 1ns/1ps
`default_nettype none
module dbio_field_model
    import dbio_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic reset_n, // Async reset, active low
    input wire logic [IN_W-1:0] pinsSet, // Wanted input pin levels
    input wire logic [KEY_W-1:0] keysSet, // Wanted key states
    input wire logic [OUT_W-1:0] outsSet, // Wanted output levels
    input wire logic driveEnable, // Wanted servo-on state
    output logic [IN_W-1:0] hwInputPins, // Driven input pins
    output logic [KEY_W-1:0] keyPressed, // Driven key states
    output logic [OUT_W-1:0] outputPins, // Driven output levels
    output logic servoOff // Drive disabled, analog wiring removed
);
    // ------------------------------------------------------------
    // Field levels settle one clock after the bench asks
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hwInputPins <= 9'h000;
            keyPressed <= 5'h00;
            outputPins <= 6'h00;
            servoOff <= 1'h1;
        end else begin
            hwInputPins <= pinsSet;
            keyPressed <= keysSet;
            outputPins <= outsSet;
            servoOff <= !driveEnable;
        end
    end
endmodule : dbio_field_model
`default_nettype wire

// >>> sim/testbench.sv
// Self-checking testbench for the digital I/O parameter bank
`timescale 1ns/1ps
`default_nettype none
module testbench
    import dbio_pkg::*;
;
    logic clk = 1'h0;
    logic reset_n = 1'h0;
    dbio_req_t req = '0;
    logic [DATA_W-1:0] rdData;
    logic rdValid;
    logic wrDone;
    logic [IN_W-1:0] hwInputPins;
    logic [IN_W-1:0] effInputs;
    logic [IN_W-1:0] inputSourceSelect = 9'h000;
    logic [KEY_W-1:0] keyPressed;
    logic [OUT_W-1:0] outputPins;
    logic specialParamGuard = 1'h0;
    dbio_cal_t calStart;
    logic [IN_W-1:0] pinsSet = 9'h000;
    logic [KEY_W-1:0] keysSet = 5'h00;
    logic [OUT_W-1:0] outsSet = 6'h00;
    logic servoOff;
    logic driveEnable = 1'h1;
    int errorCnt = 0;
    int checkCount = 0;
    logic [DATA_W-1:0] rdVal;
    dbio_cal_t calSeen;
    logic [IN_W-1:0] expIn;
    logic [4:0] calTab [0:6] = '{5'h00, 5'h10, 5'h08, 5'h04, 5'h02,
                                 5'h1e, 5'h01};
    logic [IN_W-1:0] selTab [0:1] = '{9'h0f0, 9'h1ff};
    logic [IN_W-1:0] softTab [0:1] = '{9'h133, 9'h1ff};
    logic [IN_W-1:0] pinTab [0:1] = '{9'h0a5, 9'h000};

    dbio_param_bank i_dut (.clk(clk), .reset_n(reset_n), .req(req),
        .rdData(rdData), .rdValid(rdValid), .wrDone(wrDone),
        .hwInputPins(hwInputPins), .inputSourceSelect(inputSourceSelect),
        .keyPressed(keyPressed), .outputPins(outputPins),
        .specialParamGuard(specialParamGuard), .effInputs(effInputs),
        .calStart(calStart));

    dbio_field_model i_field (.clk(clk), .reset_n(reset_n),
        .pinsSet(pinsSet), .keysSet(keysSet), .outsSet(outsSet),
        .driveEnable(driveEnable),
        .hwInputPins(hwInputPins), .keyPressed(keyPressed),
        .outputPins(outputPins), .servoOff(servoOff));

    always #25 clk = ~clk;

    // ------------------------------------------------------------
    // Access and compare tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] exp);
        checkCount++;
        if (seen !== exp) begin
            errorCnt++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // One-cycle request, answer sampled mid-cycle after it is taken
    task automatic access(input logic wr, input logic panel,
                          input logic [ADDR_W-1:0] addr,
                          input logic [DATA_W-1:0] data);
        @(posedge clk);
        req <= '{wr: wr, rd: !wr, panel: panel, addr: addr, data: data};
        @(posedge clk);
        req <= '0;
        @(negedge clk);
        rdVal = rdData;
        calSeen = calStart;
        chk("ack", {15'h0000, wr ? wrDone : rdValid}, 16'h0001);
        @(posedge clk);
    endtask : access

    task automatic stopTest;
        $display("checks %0d mismatches %0d", checkCount, errorCnt);
        if (errorCnt == 0 && checkCount > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stopTest

    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (5000) @(posedge clk);
        errorCnt++;
        $display("FAIL watchdog expected 0 seen 1");
        stopTest();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        reset_n <= 1'h1;
        access(1'h0, 1'h0, INPUT_STATE_OFS, 16'h0000);
        chk("input_reset", rdVal, 16'h0000);
        access(1'h0, 1'h0, CAL_CMD_OFS, 16'h0000);
        chk("cal_reset", rdVal, 16'h0000);
        $display("test reset done");

        for (int i = 0; i < 2; i++) begin
            pinsSet <= pinTab[i];
            inputSourceSelect <= selTab[i];
            access(1'h1, 1'h0, INPUT_STATE_OFS, {7'h00, softTab[i]});
            repeat (3) @(posedge clk);
            expIn = (selTab[i] & softTab[i]) | (~selTab[i] & pinTab[i]);
            access(1'h0, 1'h0, INPUT_STATE_OFS, 16'h0000);
            chk("input_state", rdVal, {7'h00, expIn});
            chk("eff_inputs", {7'h00, effInputs}, {7'h00, expIn});
        end
        chk("input_max", rdVal, 16'h01ff);
        access(1'h0, 1'h1, INPUT_STATE_OFS, 16'h0000);
        chk("input_panel", rdVal, 16'h0000);
        $display("test source select done");

        keysSet <= 5'h15;
        outsSet <= 6'h3f;
        repeat (3) @(posedge clk);
        access(1'h0, 1'h1, KEYPAD_STATE_OFS, 16'h0000);
        chk("keypad", rdVal, 16'h0015);
        access(1'h1, 1'h0, KEYPAD_STATE_OFS, 16'h001f);
        access(1'h0, 1'h0, KEYPAD_STATE_OFS, 16'h0000);
        chk("keypad_ro", rdVal, 16'h0015);
        for (int p = 0; p < 2; p++) begin
            access(1'h0, p[0], OUTPUT_STATE_OFS, 16'h0000);
            chk("output", rdVal, 16'h003f);
        end
        access(1'h1, 1'h0, OUTPUT_STATE_OFS, 16'h0000);
        access(1'h0, 1'h0, OUTPUT_STATE_OFS, 16'h0000);
        chk("output_ro", rdVal, 16'h003f);
        $display("test status done");

        specialParamGuard <= 1'h1;
        driveEnable <= 1'h0;
        for (int c = 0; c <= 6; c++) begin
            access(1'h1, 1'h0, CAL_CMD_OFS, 16'(c));
            chk("cal_pulse", 16'(calSeen), 16'(calTab[c]));
            chk("servo_off", {15'h0000, servoOff}, 16'h0001);
            access(1'h0, 1'h0, CAL_CMD_OFS, 16'h0000);
            chk("cal_code", rdVal, 16'(c));
        end
        access(1'h1, 1'h0, CAL_CMD_OFS, 16'h0007);
        access(1'h0, 1'h0, CAL_CMD_OFS, 16'h0000);
        chk("cal_range", rdVal, 16'h0006);
        specialParamGuard <= 1'h0;
        access(1'h1, 1'h0, CAL_CMD_OFS, 16'h0005);
        chk("cal_locked", {11'h000, calSeen}, 16'h0000);
        $display("test calibration done");

        reset_n <= 1'h0;
        @(posedge clk);
        reset_n <= 1'h1;
        access(1'h0, 1'h0, CAL_CMD_OFS, 16'h0000);
        chk("cal_rereset", rdVal, 16'h0000);
        $display("test mid-run reset done");
        stopTest();
    end
endmodule : testbench
`default_nettype wire
